// File: bench/lcd_display_memory_scan_tb_top.sv
`timescale 1ns/1ns
`include "lcds_params.svh"
module lcd_display_memory_scan_tb_top;
   logic mclk, reset_n, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid;
   logic sync_i, sync_o, sync_oe, peer_en;
   logic [7:0] awaddr, araddr, rv;
   logic [2:0] lv;
   logic [31:0] wdata, rdata, rd;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, resp;
   logic [41:0][2:0] cols;
   logic [7:0][2:0] rows, duals;
   logic [7:0] shadow [0:1][0:49];
   integer seed = 88605;
   int fail_count = 0;
   int cmp_count = 0;
   int n, bad;

   always #5 mclk = ~mclk;

   lcds_core dut (.mclk(mclk), .reset_n(reset_n), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .column_outputs(cols), .low_row_outputs(rows),
      .dual_row_column_pins(duals), .sync_i(sync_i), .sync_o(sync_o),
      .sync_oe(sync_oe));

   lcds_peer_sync peer (.mclk(mclk), .reset_n(reset_n), .enable(peer_en),
      .sync_pulse(sync_i));

   task automatic conclude();
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] got,
                      input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", nm, exp, got);
      end
   endtask

   function automatic logic [2:0] exp_lvl(input logic sel, input logic pol,
                                          input logic is_row);
      if (is_row) begin
         exp_lvl = sel ? (pol ? `LCDS_LVL_5 : `LCDS_LVL_0)
                       : (pol ? `LCDS_LVL_1 : `LCDS_LVL_4);
      end else begin
         exp_lvl = sel ? (pol ? `LCDS_LVL_0 : `LCDS_LVL_5)
                       : (pol ? `LCDS_LVL_2 : `LCDS_LVL_3);
      end
   endfunction

   task automatic hang(input string nm);
      $display("unexpected %s expected answer seen none", nm);
      fail_count++;
      conclude();
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d,
                     input logic [3:0] s, output logic [1:0] r);
      int k;
      logic got;
      k = 0;
      got = 1'b0;
      r = 2'h3;
      awaddr <= a;
      wdata <= {24'($random(seed)), d};
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!got && k < 100) begin
         @(posedge mclk);
         k++;
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
         if (bvalid === 1'b1) begin
            got = 1'b1;
            r = bresp;
            bready <= 1'b0;
         end
      end
      if (!got) hang("write answer");
      @(posedge mclk);
   endtask

   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d,
                         output logic [1:0] r);
      int k;
      logic got;
      k = 0;
      got = 1'b0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!got && k < 100) begin
         @(posedge mclk);
         k++;
         if (arready === 1'b1) arvalid <= 1'b0;
         if (rvalid === 1'b1) begin
            got = 1'b1;
            d = rdata;
            r = rresp;
            rready <= 1'b0;
         end
      end
      if (!got) hang("read answer");
      @(posedge mclk);
   endtask

   task automatic cmd(input logic [7:0] c);
      logic [1:0] r;
      wr(`LCDS_OFS_CMD, c, 4'hF, r);
   endtask

   task automatic dat(input logic [7:0] c);
      logic [1:0] r;
      wr(`LCDS_OFS_DATA, c, 4'hF, r);
   endtask

   // Only pointer and bank bits are compared; scan state moves freely.
   task automatic stat(input logic [5:0] p, input logic b, input string nm);
      logic [31:0] d;
      logic [1:0] r;
      rd_reg(`LCDS_OFS_STAT, d, r);
      chk(nm, d & 32'h0000043F, {21'h0, b, 4'h0, p});
   endtask

   task automatic frame_len(output int len);
      len = 0;
      do begin
         @(posedge mclk);
         len++;
         if (!(cols[0] inside {3'h0, 3'h2, 3'h3, 3'h5}) ||
             !(duals[0] inside {3'h0, 3'h2, 3'h3, 3'h5}) ||
             !(rows[0] inside {3'h0, 3'h1, 3'h4, 3'h5})) bad++;
      end while (sync_o !== 1'b1 && len < 40000);
      if (len >= 40000) hang("frame sync");
   endtask

   initial begin
      mclk = 1'b0;
      reset_n = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready, peer_en} = 6'h00;
      {awaddr, araddr, wstrb, wdata} = 52'h0;
      bad = 0;
      repeat (12) @(posedge mclk);
      reset_n <= 1'b1;
      @(posedge mclk);
      rd_reg(`LCDS_OFS_CFG, rd, resp);
      chk("config after reset", rd, 32'h0);
      stat(6'h00, 1'b0, "pointer after reset");
      wr(8'h10, 8'h00, 4'hF, resp);
      chk("unmapped write resp", 32'(resp), 32'(`LCDS_RESP_SLVERR));
      rd_reg(8'h14, rd, resp);
      chk("unmapped read resp", 32'(resp), 32'(`LCDS_RESP_SLVERR));
      for (int b = 0; b < 2; b++) begin
         cmd({1'b1, b[0], 6'h00});
         cmd(8'h21);
         for (int i = 0; i < 50; i++) begin
            shadow[b][i] = 8'($random(seed));
            dat(shadow[b][i]);
         end
         stat(`LCDS_PTR_LIMIT, b[0], "pointer after fill");
      end
      dat(8'hAA);
      stat(6'h33, 1'b1, "pointer past end");
      cmd(8'hC0);
      cmd(8'h22);
      shadow[1][0] = 8'h5A;
      dat(8'h5A);
      stat(6'h3F, 1'b1, "pointer wrap down");
      cmd(8'h85);
      cmd(8'h28);
      rv = 8'($random(seed));
      shadow[0][5] &= rv;
      dat(rv);
      cmd(8'h2C);
      rv = 8'($random(seed));
      shadow[0][5] |= rv;
      dat(rv);
      stat(6'h05, 1'b0, "pointer hold");
      cmd(8'h87);
      cmd(8'h7B);
      shadow[0][7] |= 8'h08;
      cmd(8'h60);
      shadow[0][8] &= 8'hFE;
      stat(6'h08, 1'b0, "bit op pointer");
      cmd(8'h8A);
      cmd(8'h31);
      rv = 8'($random(seed));
      shadow[0][10] = rv;
      dat(rv);
      stat(6'h0F, 1'b0, "char step");
      cmd(8'h51);
      shadow[0][15][7] = 1'b1;
      stat(6'h14, 1'b0, "cursor step");
      wr(`LCDS_OFS_DATA, 8'h00, 4'hE, resp);
      stat(6'h14, 1'b0, "partial byte");
      cmd(8'h32);
      rv = 8'($random(seed));
      shadow[0][20] = rv;
      dat(rv);
      stat(6'h0F, 1'b0, "char step down");
      for (int b = 0; b < 2; b++) begin
         cmd({1'b1, b[0], 6'h00});
         cmd(8'h25);
         for (int i = 0; i < 50; i++) begin
            rd_reg(`LCDS_OFS_DATA, rd, resp);
            chk("display word", rd, {24'h0, shadow[b][i]});
         end
         rd_reg(`LCDS_OFS_DATA, rd, resp);
         chk("word beyond end", rd, 32'h0);
      end
      for (int m = 0; m < 8; m++) begin
         cmd({5'h00, m[2:0]});
         rd_reg(`LCDS_OFS_CFG, rd, resp);
         chk("mode code", 32'(rd[13:11]), 32'(m));
      end
      cmd(8'h08);
      chk("sync drive", 32'(sync_oe), 32'h1);
      for (int f = 0; f < 2; f++) begin
         cmd({4'h4, 4'(f)});
         frame_len(n);
         frame_len(n);
         chk("frame length", n, 8 * (f + 1) * `LCDS_ROW_BASE);
      end
      chk("drive levels", bad, 0);
      // A frame has just begun, so row 0 stands long enough to inspect.
      rd_reg(`LCDS_OFS_STAT, rd, resp);
      chk("row at frame start", 32'(rd[14:11]), 32'h0);
      for (int c = 0; c < 50; c++) begin
         lv = exp_lvl(shadow[0][c][rd[13:11]], rd[15], 1'b0);
         if (c < 42) chk("column level", 32'(cols[c]), 32'(lv));
         else chk("dual pin level", 32'(duals[c - 42]), 32'(lv));
      end
      for (int i = 0; i < 8; i++) begin
         lv = exp_lvl(i == rd[13:11], rd[15], 1'b1);
         chk("row level", 32'(rows[i]), 32'(lv));
      end
      peer_en <= 1'b1;
      cmd(8'h00);
      chk("sync drive off", 32'(sync_oe), 32'h0);
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (sync_i !== 1'b1 && n < 5000);
      if (sync_i !== 1'b1) hang("peer sync");
      // The pulse passes two synchroniser stages before the frame restarts.
      repeat (3) @(posedge mclk);
      rd_reg(`LCDS_OFS_STAT, rd, resp);
      chk("row after sync", 32'(rd[14:11]), 32'h0);
      conclude();
   end
endmodule

// File: bench/lcds_peer_sync.sv
`timescale 1ns/1ns
// Stand-in for a second chip that owns the frame timing.
module lcds_peer_sync #(
   parameter int PERIOD = 3000
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // Control and sync line
   input wire logic enable,
   output logic sync_pulse
);
   logic [15:0] cnt_r;
   always_ff @(posedge mclk) begin
      if (!reset_n || !enable) begin
         cnt_r <= 16'h0000;
         sync_pulse <= 1'b0;
      end else begin
         // The line rests low between pulses, as a real driver would.
         sync_pulse <= (cnt_r == 16'(PERIOD - 1));
         cnt_r <= (cnt_r == 16'(PERIOD - 1)) ? 16'h0000 : cnt_r + 16'h0001;
      end
   end
endmodule

// File: common/lcds_params.svh
`ifndef LCDS_PARAMS_SVH
`define LCDS_PARAMS_SVH
// Register byte offsets on the AXI4-Lite port.
`define LCDS_OFS_CMD 8'h00
`define LCDS_OFS_DATA 8'h04
`define LCDS_OFS_STAT 8'h08
`define LCDS_OFS_CFG 8'h0C
// AXI responses.
`define LCDS_RESP_OKAY 2'h0
`define LCDS_RESP_SLVERR 2'h2
// Display memory geometry.
`define LCDS_WORDS 7'h32
`define LCDS_PTR_LIMIT 6'h32
`define LCDS_COLS 50
`define LCDS_COLS_16 6'h2A
// Pointer step sizes.
`define LCDS_STEP_ONE 6'h01
`define LCDS_STEP_CHAR 6'h05
// Command opcodes in bits 7:5 (bit 7 set means pointer load).
`define LCDS_OP_SMM 3'h0
`define LCDS_OP_DMODE 3'h1
`define LCDS_OP_SFF 3'h2
`define LCDS_OP_BIT 3'h3
// Scan timing: cycles per row at the fastest frame rate setting.
`define LCDS_ROW_BASE 20'h00400
// Drive levels.
`define LCDS_LVL_0 3'h0
`define LCDS_LVL_1 3'h1
`define LCDS_LVL_2 3'h2
`define LCDS_LVL_3 3'h3
`define LCDS_LVL_4 3'h4
`define LCDS_LVL_5 3'h5
`endif

// File: common/lcds_pkg.sv
package lcds_pkg;
   typedef enum logic [2:0] {
      DM_WRITE, DM_READ, DM_AND, DM_OR, DM_CHAR
   } lcds_dmode_e;
   typedef enum logic [1:0] {
      ST_HOLD, ST_INC, ST_DEC
   } lcds_step_e;
   typedef struct packed {
      logic [2:0] mode_code;
      logic sync_out;
      logic scan_bank;
      lcds_dmode_e dmode;
      lcds_step_e step;
      logic [3:0] frame_sel;
   } lcds_cfg_s;
endpackage

// File: core/lcds_core.sv
`timescale 1ns/1ns
`include "lcds_params.svh"
// Summary of operation
// - Pointer is 6-bit counter plus bank flag
// - Pointer load command sets bank and address
// - Bank flag selects memory bank
// - Counter addresses word 00H to 31H
// - Data transfers step pointer by mode setting
// - Bit commands step pointer as encoded
// - Character mode steps by five
// - Counter wraps over full 6-bit range
// - Addresses 32H-3FH access no memory
// - Two banks of 50 bytes
// - Written bytes transformed by data mode
// - Bit commands set or clear bits
// - Read mode returns pointed word
// - Refresh reads memory independent of host
// - Eight-row scan uses selected bank
// - Sixteen-row single chip uses 42 columns
// - Sixteen-row multi chip uses 50 columns
// - Drive level chosen per phase
// - Timing from frame rate and mode
// - Sync output once per frame
// - Sync input realigns frame
// - Mode code assigns pin roles
// - Act only on complete bytes
module lcds_core
   import lcds_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // AXI4-Lite write channels
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // AXI4-Lite read channels
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Panel drive levels
   output logic [41:0][2:0] column_outputs,
   output logic [7:0][2:0] low_row_outputs,
   output logic [7:0][2:0] dual_row_column_pins,
   // Frame sync pin
   input wire logic sync_i,
   output logic sync_o,
   output logic sync_oe
);
   logic [7:0] mem [0:2*`LCDS_COLS-1];
   logic aw_full_r, w_full_r;
   logic [7:0] aw_addr_r;
   logic [7:0] w_data_r;
   logic w_strb0_r;
   logic [5:0] ptr_r;
   logic bank_select_flag_r;
   lcds_cfg_s cfg_r;
   logic [19:0] div_r;
   logic [3:0] row_r;
   logic pol_r;
   logic sync_s1_r, sync_s2_r, sync_s3_r;
   logic wr_fire, wr_cmd, wr_dat, ar_got, rd_dat;
   logic [7:0] cmd;
   logic ptr_ok;
   logic [6:0] host_idx;
   logic [7:0] host_word, host_nv;
   logic host_we;
   logic is_bit, is_curs, is_load_pointer_immediate_cmd;
   logic [5:0] ptr_nxt;
   logic row_tick, frame_last, sync_align;
   logic [3:0] rows_last;
   logic [19:0] div_load;
   logic [49:0] col_on;

   function automatic logic [5:0] step_ptr(input logic [5:0] p,
                                            input lcds_step_e s,
                                            input logic [5:0] amt);
      case (s)
         ST_INC: step_ptr = p + amt;
         ST_DEC: step_ptr = p - amt;
         default: step_ptr = p;
      endcase
   endfunction

   function automatic logic [2:0] level(input logic sel, input logic pol,
                                        input logic is_row);
      if (is_row) begin
         level = sel ? (pol ? `LCDS_LVL_5 : `LCDS_LVL_0)
                     : (pol ? `LCDS_LVL_1 : `LCDS_LVL_4);
      end else begin
         level = sel ? (pol ? `LCDS_LVL_0 : `LCDS_LVL_5)
                     : (pol ? `LCDS_LVL_2 : `LCDS_LVL_3);
      end
   endfunction

   // Write address and data are taken in either order; both must be held.
   assign wr_fire = aw_full_r && w_full_r && !bvalid;
   assign ar_got = arvalid && arready;
   assign cmd = w_data_r;
   // A word with its low byte lane disabled carries no whole byte.
   assign wr_cmd = wr_fire && w_strb0_r && aw_addr_r == `LCDS_OFS_CMD;
   assign wr_dat = wr_fire && w_strb0_r && aw_addr_r == `LCDS_OFS_DATA;
   assign rd_dat = ar_got && araddr == `LCDS_OFS_DATA &&
                   cfg_r.dmode == DM_READ;
   assign is_load_pointer_immediate_cmd = wr_cmd && cmd[7];
   assign is_bit = wr_cmd && cmd[7:5] == `LCDS_OP_BIT;
   assign is_curs = wr_cmd && cmd[7:5] == `LCDS_OP_SFF && cmd[4];

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         aw_full_r <= 1'b0;
         awready <= 1'b0;
      end else if (awvalid && awready) begin
         aw_full_r <= 1'b1;
         awready <= 1'b0;
         aw_addr_r <= awaddr;
      end else begin
         if (wr_fire) begin
            aw_full_r <= 1'b0;
         end
         awready <= !aw_full_r && !bvalid && !wr_fire;
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         w_full_r <= 1'b0;
         wready <= 1'b0;
      end else if (wvalid && wready) begin
         w_full_r <= 1'b1;
         wready <= 1'b0;
         w_data_r <= wdata[7:0];
         w_strb0_r <= wstrb[0];
      end else begin
         if (wr_fire) begin
            w_full_r <= 1'b0;
         end
         wready <= !w_full_r && !bvalid && !wr_fire;
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         bvalid <= 1'b0;
         bresp <= `LCDS_RESP_OKAY;
      end else if (wr_fire) begin
         bvalid <= 1'b1;
         bresp <= (aw_addr_r == `LCDS_OFS_CMD ||
                   aw_addr_r == `LCDS_OFS_DATA) ?
                  `LCDS_RESP_OKAY : `LCDS_RESP_SLVERR;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= `LCDS_RESP_OKAY;
      end else if (ar_got) begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rresp <= `LCDS_RESP_OKAY;
         case (araddr)
            `LCDS_OFS_DATA: rdata <= {24'h00_0000,
                                      rd_dat ? host_word : 8'h00};
            `LCDS_OFS_STAT: rdata <= {16'h0000, pol_r, row_r,
                                      bank_select_flag_r, 4'h0, ptr_r};
            `LCDS_OFS_CFG: rdata <= {18'h00000, cfg_r};
            default: begin
               rdata <= 32'h0000_0000;
               rresp <= `LCDS_RESP_SLVERR;
            end
         endcase
      end else begin
         if (rready) begin
            rvalid <= 1'b0;
         end
         arready <= !rvalid || rready;
      end
   end

   // Host side of the memory. The refresh scan has its own read path, so
   // host traffic never stalls or disturbs the panel.
   assign ptr_ok = ptr_r < `LCDS_PTR_LIMIT;
   assign host_idx = bank_select_flag_r ? `LCDS_WORDS + {1'b0, ptr_r}
                                        : {1'b0, ptr_r};
   assign host_word = ptr_ok ? mem[host_idx] : 8'h00;

   always_comb begin
      host_nv = host_word;
      host_we = 1'b0;
      if (wr_dat && cfg_r.dmode != DM_READ) begin
         host_we = ptr_ok;
         case (cfg_r.dmode)
            DM_AND: host_nv = host_word & cmd;
            DM_OR: host_nv = host_word | cmd;
            default: host_nv = cmd;
         endcase
      end else if (is_bit) begin
         host_we = ptr_ok;
         host_nv = cmd[4] ? host_word | (8'h01 << cmd[2:0])
                          : host_word & ~(8'h01 << cmd[2:0]);
      end else if (is_curs) begin
         host_we = ptr_ok;
         host_nv = {cmd[0], host_word[6:0]};
      end
   end

   always_ff @(posedge mclk) begin
      if (host_we) begin
         mem[host_idx] <= host_nv;
      end
   end

   always_comb begin
      ptr_nxt = ptr_r;
      if (wr_dat || rd_dat) begin
         ptr_nxt = step_ptr(ptr_r, cfg_r.step,
                            cfg_r.dmode == DM_CHAR ? `LCDS_STEP_CHAR
                                                   : `LCDS_STEP_ONE);
      end else if (is_bit) begin
         ptr_nxt = cmd[3] ? ptr_r + `LCDS_STEP_ONE : ptr_r;
      end else if (is_curs) begin
         ptr_nxt = step_ptr(ptr_r, cfg_r.step, `LCDS_STEP_CHAR);
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         ptr_r <= 6'h00;
         bank_select_flag_r <= 1'b0;
      end else if (is_load_pointer_immediate_cmd) begin
         bank_select_flag_r <= cmd[6];
         ptr_r <= cmd[5:0];
      end else begin
         ptr_r <= ptr_nxt;
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         cfg_r <= '0;
      end else if (wr_cmd && !cmd[7]) begin
         case (cmd[7:5])
            `LCDS_OP_SMM: begin
               cfg_r.mode_code <= cmd[2:0];
               cfg_r.sync_out <= cmd[3];
               cfg_r.scan_bank <= cmd[4];
            end
            `LCDS_OP_DMODE: begin
               cfg_r.dmode <= lcds_dmode_e'(cmd[4:2]);
               cfg_r.step <= lcds_step_e'(cmd[1:0]);
            end
            `LCDS_OP_SFF: begin
               if (!cmd[4]) begin
                  cfg_r.frame_sel <= cmd[3:0];
               end
            end
            default: begin
            end
         endcase
      end
   end

   // Frame timing. The row period scales with the frame rate setting.
   assign rows_last = cfg_r.mode_code[2] ? 4'hF : 4'h7;
   assign div_load = 20'(({1'b0, cfg_r.frame_sel} + 5'h01) *
                         `LCDS_ROW_BASE) - 20'h00001;
   assign row_tick = div_r == 20'h00000;
   assign frame_last = row_tick && row_r == rows_last;
   assign sync_align = !cfg_r.sync_out && sync_s2_r && !sync_s3_r;

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         sync_s1_r <= 1'b0;
         sync_s2_r <= 1'b0;
         sync_s3_r <= 1'b0;
      end else begin
         sync_s1_r <= sync_i;
         sync_s2_r <= sync_s1_r;
         sync_s3_r <= sync_s2_r;
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         div_r <= 20'h00000;
         row_r <= 4'h0;
         pol_r <= 1'b0;
      end else if (sync_align) begin
         div_r <= div_load;
         row_r <= 4'h0;
      end else if (row_tick) begin
         div_r <= div_load;
         row_r <= frame_last ? 4'h0 : row_r + 4'h1;
         if (frame_last) begin
            pol_r <= !pol_r;
         end
      end else begin
         div_r <= div_r - 20'h00001;
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         sync_o <= 1'b0;
         sync_oe <= 1'b0;
      end else begin
         sync_oe <= cfg_r.sync_out;
         sync_o <= cfg_r.sync_out && frame_last;
      end
   end

   // Refresh read: sixteen-row modes take rows 8-15 from bank 1.
   genvar c;
   generate
      for (c = 0; c < `LCDS_COLS; c = c + 1) begin : g_col
         logic scan_bank;
         logic [6:0] scan_idx;
         assign scan_bank = cfg_r.mode_code[2] ? row_r[3]
                                               : cfg_r.scan_bank;
         assign scan_idx = scan_bank ? `LCDS_WORDS + 7'(c) : 7'(c);
         assign col_on[c] = mem[scan_idx][row_r[2:0]];
      end
      for (c = 0; c < 42; c = c + 1) begin : g_cdrv
         always_ff @(posedge mclk) begin
            if (!reset_n) begin
               column_outputs[c] <= `LCDS_LVL_0;
            end else begin
               column_outputs[c] <= level(col_on[c], pol_r, 1'b0);
            end
         end
      end
      for (c = 0; c < 8; c = c + 1) begin : g_rdrv
         logic [3:0] low_row;
         logic dual_is_row;
         assign low_row = (cfg_r.mode_code[2] && !cfg_r.mode_code[1]) ?
                          4'(c + 8) : 4'(c);
         assign dual_is_row = cfg_r.mode_code == 3'h7;
         always_ff @(posedge mclk) begin
            if (!reset_n) begin
               low_row_outputs[c] <= `LCDS_LVL_0;
               dual_row_column_pins[c] <= `LCDS_LVL_0;
            end else begin
               low_row_outputs[c] <= level(row_r == low_row, pol_r, 1'b1);
               dual_row_column_pins[c] <= dual_is_row ?
                  level(row_r == 4'(15 - c), pol_r, 1'b1) :
                  level(col_on[42 + c], pol_r, 1'b0);
            end
         end
      end
   endgenerate

   a_load_pointer_immediate_cmd_load: assert property (@(posedge mclk) disable iff (!reset_n)
      is_load_pointer_immediate_cmd |=> ptr_r == $past(cmd[5:0]) &&
                  bank_select_flag_r == $past(cmd[6]))
      else $error("pointer load not taken");
   a_data_inc: assert property (@(posedge mclk) disable iff (!reset_n)
      wr_dat && cfg_r.step == ST_INC && cfg_r.dmode != DM_CHAR
      |=> ptr_r == $past(ptr_r) + 6'h01)
      else $error("pointer did not step by one");
   a_char_dec: assert property (@(posedge mclk) disable iff (!reset_n)
      (wr_dat || is_curs) && cfg_r.step == ST_DEC && cfg_r.dmode == DM_CHAR
      |=> ptr_r == $past(ptr_r) - 6'h05)
      else $error("character step not five");
   a_wrap_down: assert property (@(posedge mclk) disable iff (!reset_n)
      wr_dat && ptr_r == 6'h00 && cfg_r.step == ST_DEC &&
      cfg_r.dmode != DM_CHAR |=> ptr_r == 6'h3F)
      else $error("pointer did not wrap");
   a_oob_no_write: assert property (@(posedge mclk) disable iff (!reset_n)
      ptr_r >= 6'h32 |-> !host_we)
      else $error("write outside memory");
   a_partial_byte: assert property (@(posedge mclk) disable iff (!reset_n)
      wr_fire && !w_strb0_r |=> $stable(ptr_r) && $stable(cfg_r))
      else $error("partial byte acted on");
   a_pol_flip: assert property (@(posedge mclk) disable iff (!reset_n)
      frame_last && !sync_align |=> pol_r != $past(pol_r) && row_r == 4'h0)
      else $error("polarity not alternated");
   a_sync_pulse: assert property (@(posedge mclk) disable iff (!reset_n)
      sync_o |-> sync_oe ##1 !sync_o)
      else $error("sync pulse malformed");
   a_sync_align: assert property (@(posedge mclk) disable iff (!reset_n)
      sync_align |=> row_r == 4'h0 && div_r == $past(div_load))
      else $error("frame not aligned to sync");
endmodule
